// ### rtl/rtcip_cfg.svh
// Constants for the real-time clock two-wire target port
`ifndef RTCIP_CFG_SVH
`define RTCIP_CFG_SVH
`define RTCIP_ADDR_WR 8'hac
`define RTCIP_ADDR_RD 8'had
`define RTCIP_DIR_BIT 0
`define RTCIP_BIT_LAST 3'h7
`define RTCIP_BIT_FIRST 3'h7
`define RTCIP_PAGE_HI 7
`define RTCIP_PAGE_LO 3
`define RTCIP_WORD_HI 2
`define RTCIP_PTR_RST 8'h00
`define RTCIP_DIRTY_RST 8'h00
`endif

// ### rtl/rtcip_pkg.sv
// Types for the real-time clock two-wire target port
package rtcip_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX = 3'b010,
        ST_RX_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_TX_ACK = 3'b101,
        ST_IGNORE = 3'b110
    } rtcip_state_e;
endpackage : rtcip_pkg

// ### rtl/rtcip_sync.sv
// Two-stage synchroniser for one pin
`timescale 1ns/1ps
module rtcip_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : rtcip_sync

// ### rtl/rtcip_target.sv
// Two-wire target port with a transfer cache over an eight-word page
// How it works
// R1: Target only; SCL input, SDA open drain
// R2: Controller frames transfers and clocks every bit
// R3: Data changes only while SCL low
// R4: SDA edges while SCL high mark START/STOP
// R5: No repeated START; STOP comes first
// R6: New transfer only on idle bus
// R7: Nine clocks per byte, unlimited bytes
// R8: Acknowledge received bytes with low SDA
// R9: Missing read acknowledge releases SDA
// R10: First byte is address plus direction
// R11: Answer write address ACh, read ADh
// R12: Second write byte is page and word
// R13: Acknowledged byte advances word address
// R14: Unacknowledged byte keeps address
// R15: Random read via pointer write, STOP, read
// R16: Bare read continues after last address
// R17: Snapshot live page into cache at START
// R18: Cache frozen until STOP
// R19: STOP after write returns modified bytes
// R20: Foreign address is not acknowledged
// R21: Word address wraps within its page
`timescale 1ns/1ps
`include "rtcip_cfg.svh"
module rtcip_target (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [4:0] live_page,
    input wire logic [63:0] live_data,
    output logic wb_valid,
    output logic [4:0] wb_page,
    output logic [7:0] wb_mask,
    output logic [63:0] wb_data,
    output logic busy
);
    typedef struct packed {
        rtcip_pkg::rtcip_state_e st;
        logic scl_d;
        logic sda_d;
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic first;
        logic wrote;
        logic ptr_seen;
        logic drive_low;
        logic [7:0] ptr;
        logic [7:0] last;
        logic [63:0] cache;
        logic [7:0] dirty;
        logic wb_valid;
        logic [4:0] wb_page;
        logic [7:0] wb_mask;
        logic [63:0] wb_data;
    } rtcip_state_s;

    rtcip_state_s s_reg;
    rtcip_state_s s_next;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [2:0] word;
    logic [7:0] byte_in;
    logic [7:0] inc_ptr;
    logic [7:0] inc_last;

    rtcip_sync u_sync_scl (
        .clk(clk),
        .rst(rst),
        .d(scl_i),
        .q(scl_s)
    );
    rtcip_sync u_sync_sda (
        .clk(clk),
        .rst(rst),
        .d(sda_i),
        .q(sda_s)
    );

    assign scl_rise = scl_s && !s_reg.scl_d;
    assign scl_fall = !scl_s && s_reg.scl_d;
    assign start_ev = scl_s && s_reg.scl_d && s_reg.sda_d && !sda_s; // see R4
    assign stop_ev = scl_s && s_reg.scl_d && !s_reg.sda_d && sda_s; // see R4
    assign word = s_reg.ptr[`RTCIP_WORD_HI:0];
    assign byte_in = {s_reg.sh[6:0], sda_s};

    function automatic logic [7:0] rtcip_inc(input logic [7:0] p);
        rtcip_inc = {p[`RTCIP_PAGE_HI:`RTCIP_PAGE_LO], p[`RTCIP_WORD_HI:0] + 3'h1}; // see R13 see R21
    endfunction : rtcip_inc

    // Named so the word bits of the next address can be selected
    assign inc_ptr = rtcip_inc(s_reg.ptr);
    assign inc_last = rtcip_inc(s_reg.last);

    always_comb begin
        s_next = s_reg;
        s_next.scl_d = scl_s;
        s_next.sda_d = sda_s;
        s_next.wb_valid = 1'b0;
        if (stop_ev) begin
            // Only bytes touched by this transfer go back, so live time keeps running elsewhere
            if (s_reg.wrote && (s_reg.dirty != `RTCIP_DIRTY_RST)) begin
                s_next.wb_valid = 1'b1; // see R19
                s_next.wb_page = s_reg.ptr[`RTCIP_PAGE_HI:`RTCIP_PAGE_LO];
                s_next.wb_mask = s_reg.dirty;
                s_next.wb_data = s_reg.cache;
            end
            s_next.st = rtcip_pkg::ST_IDLE;
            s_next.drive_low = 1'b0;
            s_next.wrote = 1'b0;
            s_next.dirty = `RTCIP_DIRTY_RST;
        end else if (start_ev) begin
            // Repeated START unsupported: treated as a fresh START
            s_next.cache = live_data; // see R17 see R18
            s_next.dirty = `RTCIP_DIRTY_RST;
            s_next.st = rtcip_pkg::ST_ADDR;
            s_next.bitcnt = `RTCIP_BIT_FIRST;
            s_next.drive_low = 1'b0;
            s_next.wrote = 1'b0;
            s_next.ptr_seen = 1'b0;
        end else begin
            case (s_reg.st)
                rtcip_pkg::ST_IDLE: begin
                    s_next.drive_low = 1'b0;
                end
                rtcip_pkg::ST_IGNORE: begin
                    s_next.drive_low = 1'b0; // see R20
                end
                rtcip_pkg::ST_ADDR, rtcip_pkg::ST_RX: begin
                    if (scl_rise) begin
                        s_next.sh = byte_in; // see R10
                        s_next.bitcnt = s_reg.bitcnt - 3'h1;
                    end
                    if (scl_rise && s_reg.bitcnt == 3'h0) begin
                        s_next.st = rtcip_pkg::ST_RX_ACK; // see R7
                        s_next.first = (s_reg.st == rtcip_pkg::ST_ADDR);
                    end
                end
                rtcip_pkg::ST_RX_ACK: begin
                    if (scl_fall && !s_reg.drive_low) begin
                        if (s_reg.first) begin
                            if (s_reg.sh == `RTCIP_ADDR_WR || s_reg.sh == `RTCIP_ADDR_RD) begin
                                s_next.drive_low = 1'b1; // see R11
                            end else begin
                                s_next.st = rtcip_pkg::ST_IGNORE; // see R20
                            end
                        end else begin
                            s_next.drive_low = 1'b1; // see R8
                            if (!s_reg.ptr_seen) begin
                                s_next.ptr = s_reg.sh; // see R12
                                // One below, so a following read starts at the pointer itself
                                s_next.last = {s_reg.sh[`RTCIP_PAGE_HI:`RTCIP_PAGE_LO],
                                    s_reg.sh[`RTCIP_WORD_HI:0] - 3'h1}; // see R15 see R16
                                s_next.ptr_seen = 1'b1;
                            end else begin
                                s_next.cache[word*8 +: 8] = s_reg.sh;
                                s_next.dirty[word] = 1'b1;
                                s_next.wrote = 1'b1;
                            end
                        end
                    end else if (scl_fall && s_reg.drive_low) begin
                        // Ninth clock done; release or begin transmitting
                        s_next.drive_low = 1'b0;
                        s_next.bitcnt = `RTCIP_BIT_FIRST;
                        if (s_reg.first && s_reg.sh[`RTCIP_DIR_BIT]) begin
                            s_next.st = rtcip_pkg::ST_TX;
                            s_next.ptr = inc_last; // see R16
                            s_next.drive_low = !s_reg.cache[{inc_last[`RTCIP_WORD_HI:0], `RTCIP_BIT_FIRST}];
                        end else begin
                            s_next.st = rtcip_pkg::ST_RX;
                            if (!s_reg.first && s_reg.ptr_seen && s_reg.wrote) begin
                                s_next.last = s_reg.ptr;
                                s_next.ptr = rtcip_inc(s_reg.ptr); // see R13
                            end
                        end
                    end
                end
                rtcip_pkg::ST_TX: begin
                    if (scl_fall) begin
                        s_next.bitcnt = s_reg.bitcnt - 3'h1;
                        if (s_reg.bitcnt == 3'h0) begin
                            s_next.st = rtcip_pkg::ST_TX_ACK;
                            s_next.drive_low = 1'b0;
                        end else begin
                            s_next.drive_low = !s_reg.cache[{word, s_reg.bitcnt - 3'h1}]; // see R3
                        end
                    end
                end
                rtcip_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        s_next.sh = {7'h00, sda_s};
                    end
                    if (scl_fall) begin
                        if (!s_reg.sh[0]) begin
                            s_next.last = s_reg.ptr;
                            s_next.ptr = rtcip_inc(s_reg.ptr); // see R13
                            s_next.st = rtcip_pkg::ST_TX;
                            s_next.bitcnt = `RTCIP_BIT_FIRST;
                            s_next.drive_low = !s_reg.cache[{inc_ptr[`RTCIP_WORD_HI:0], `RTCIP_BIT_FIRST}];
                        end else begin
                            // Last-accessed stays one below so a bare read repeats this byte
                            s_next.last = {s_reg.ptr[`RTCIP_PAGE_HI:`RTCIP_PAGE_LO],
                                s_reg.ptr[`RTCIP_WORD_HI:0] - 3'h1}; // see R14
                            s_next.st = rtcip_pkg::ST_IGNORE; // see R9
                        end
                    end
                end
                default: begin
                    s_next.st = rtcip_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{st: rtcip_pkg::ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, bitcnt: `RTCIP_BIT_FIRST,
                       sh: 8'h00, first: 1'b0, wrote: 1'b0, ptr_seen: 1'b0, drive_low: 1'b0,
                       ptr: `RTCIP_PTR_RST, last: `RTCIP_PTR_RST, cache: 64'h0, dirty: `RTCIP_DIRTY_RST,
                       wb_valid: 1'b0, wb_page: 5'h00, wb_mask: 8'h00, wb_data: 64'h0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0; // see R1
    assign sda_oe = s_reg.drive_low;
    assign live_page = s_reg.ptr[`RTCIP_PAGE_HI:`RTCIP_PAGE_LO];
    assign wb_valid = s_reg.wb_valid;
    assign wb_page = s_reg.wb_page;
    assign wb_mask = s_reg.wb_mask;
    assign wb_data = s_reg.wb_data;
    assign busy = (s_reg.st != rtcip_pkg::ST_IDLE);
endmodule : rtcip_target

// ### tb/rtcip_assertions.sv
// Protocol checker for the two-wire target port
`timescale 1ns/1ps
module rtcip_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic wb_valid,
    input wire logic [7:0] wb_mask,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_drain_only: assert property (sda_o == 1'b0) else $error("sda_o high");
    a_idle_released: assert property (!busy |-> !sda_oe) else $error("sda held idle");
    a_change_low: assert property ($changed(sda_oe) |-> !scl_i) else $error("oe moved, scl high");
    a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*6]) else $error("low too short");
    a_start_busy: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] busy)
        else $error("start missed");
    a_stop_idle: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !busy)
        else $error("stop missed");
    a_wb_pulse: assert property (wb_valid |=> !wb_valid) else $error("wb too long");
    a_wb_masked: assert property (wb_valid |-> wb_mask != 8'h00 && !busy) else $error("wb bad");
endmodule : rtcip_assertions
bind rtcip_target rtcip_assertions chk (.clk, .rst, .scl_i, .sda_i, .sda_o, .sda_oe, .wb_valid, .wb_mask, .busy);

// ### tb/rtcip_ctrl_model.sv
// Behavioural bus controller facing the target port
`timescale 1ns/1ps
module rtcip_ctrl_model (
    input wire logic clk,
    input wire logic sda_w,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Clock stands still between frames; 160 ns per bit
    task automatic bit_io(input logic b, output logic s);
        tick(1);
        sda_low = !b;
        tick(3);
        scl = 1'b1;
        tick(4);
        s = sda_w;
        scl = 1'b0;
    endtask : bit_io
    task automatic start_c();
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask : start_c
    task automatic stop_c();
        tick(1);
        sda_low = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(8);
    endtask : stop_c
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : wr_byte
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!ack, s);
    endtask : rd_byte
endmodule : rtcip_ctrl_model

// ### tb/tb_rtc_i2c_target_port.sv
// Self-checking bench for the two-wire target port
`timescale 1ns/1ps
module tb_rtc_i2c_target_port;
    logic clk, rst, scl, m_low, sda_o, sda_oe, wb_valid, busy, ack;
    logic [4:0] live_page, wb_page, cap_page;
    logic [7:0] wb_mask, cap_mask, d;
    logic [63:0] wb_data, live_data, cap_data;
    logic [7:0] mem [32][8];
    int fails = 0, checks = 0, wbs = 0;
    // Open drain with pull-up
    wire logic sda_w = !((sda_oe && !sda_o) || m_low);
    rtcip_target dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .live_page(live_page), .live_data(live_data), .wb_valid(wb_valid), .wb_page(wb_page),
        .wb_mask(wb_mask), .wb_data(wb_data), .busy(busy));
    rtcip_ctrl_model ctl (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_low(m_low));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always_comb
        for (int w = 0; w < 8; w++) live_data[8*w +: 8] = mem[live_page][w];
    // Live array takes back modified bytes only
    always @(posedge clk) begin
        if (wb_valid === 1'b1) begin
            wbs <= wbs + 1;
            cap_page <= wb_page;
            cap_mask <= wb_mask;
            for (int w = 0; w < 8; w++) begin
                cap_data[8*w +: 8] <= wb_mask[w] ? wb_data[8*w +: 8] : 8'h00;
                if (wb_mask[w]) mem[wb_page][w] <= wb_data[8*w +: 8];
            end
        end
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic open_ptr(input logic [7:0] p);
        ctl.start_c();
        ctl.wr_byte(8'hac, ack);
        chk("ack wr addr", 1, ack);
        ctl.wr_byte(p, ack);
        chk("ack pointer", 1, ack);
    endtask : open_ptr
    initial begin
        #400us;
        fails++;
        report_and_stop();
    end
    initial begin
        logic [4:0] pg;
        logic [2:0] w, x;
        logic [7:0] old [8];
        logic [7:0] em;
        logic [63:0] ed;
        int n, n0;
        void'($urandom(78937));
        rst = 1'b1;
        for (int i = 0; i < 256; i++) mem[i / 8][i % 8] = 8'($urandom);
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        for (int t = 0; t < 4; t++) begin
            do d = 8'($urandom); while (d[7:1] == 7'h56);
            n0 = wbs;
            ctl.start_c();
            ctl.wr_byte(d, ack);
            chk("foreign ack", 0, ack);
            ctl.wr_byte(8'h00, ack);
            chk("ignored byte", 0, ack);
            ctl.stop_c();
            chk("foreign wb", n0, wbs);
            chk("busy idle", 0, busy);
        end
        for (int t = 0; t < 6; t++) begin
            pg = 5'($urandom);
            w = 3'($urandom_range(7, 5));
            n = $urandom_range(3, 1);
            em = 8'h00;
            ed = 64'h0;
            open_ptr({pg, w});
            for (int k = 0; k < n; k++) begin
                d = 8'($urandom);
                x = w + 3'(k);
                ctl.wr_byte(d, ack);
                chk("ack data", 1, ack);
                em[x] = 1'b1;
                ed[8*x +: 8] = d;
            end
            n0 = wbs;
            ctl.stop_c();
            chk("wb count", n0 + 1, wbs);
            chk("wb page", 64'(pg), 64'(cap_page));
            chk("wb mask", 64'(em), 64'(cap_mask));
            chk("wb data", ed, cap_data);
            open_ptr({pg, w});
            ctl.stop_c();
            chk("wb idle", n0 + 1, wbs);
            for (int j = 0; j < 8; j++) old[j] = mem[pg][j];
            ctl.start_c();
            ctl.wr_byte(8'had, ack);
            chk("ack rd addr", 1, ack);
            // Live page moves on under the cache
            for (int j = 0; j < 8; j++) mem[pg][j] = ~old[j];
            for (int k = 0; k <= n; k++) begin
                x = w + 3'(k);
                ctl.rd_byte(k < n, d);
                chk("read byte", 64'(old[x]), 64'(d));
            end
            ctl.stop_c();
            ctl.start_c();
            ctl.wr_byte(8'had, ack);
            ctl.rd_byte(1'b0, d);
            chk("reread", 64'(mem[pg][x]), 64'(d));
            ctl.stop_c();
        end
        report_and_stop();
    end
endmodule : tb_rtc_i2c_target_port
